// ===== core/osr_regs.sv
`timescale 1ns/100ps
// Oscillator output settings and operation status register bank.
// Assumes a command parser presents one decoded access per cycle on cmd_i
// and that the condition bits come from the instrument, synchronous to mclk_i.

// Overview of operation
// - Output state code 0 turns AC and DC off, 1 turns AC off, 2 turns both on.
// - Code 1 turns AC off and gives DC back the state it had before.
// - A query of output state returns the code actually in effect.
// - DC bias is a signed hundredths value clamped to -10.00..10.00 V and read back as stored.
// - Amplitude writes use the selected unit unless an rms or peak suffix overrides it.
// - Amplitude is limited to 0..7.07 Vrms or 0..10.00 Vpk.
// - The unit setting picks rms or peak and sets the unit of amplitude read back.
// - Every status register is 16 bits with its top bit reading zero.
// - Status writes take any 16-bit value and store the low fifteen bits.
// - Status queries therefore never exceed 32767.
// - The condition register is query-only and shows the present condition bits.
// - The event-enable register is writable and readable with the same masking.
// - The event register is readable and returns its latched bits.
// - Event bits latch on rising edges gated by the rising filter and falling by the falling one.
// - Falling and rising filter registers are writable and readable with top bit masking.
module osr_regs
	import osr_pkg::*;
#(
	parameter int SW = 16
)
(
	// Clock, reset and enable
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Command port
	input wire osr_cmd_s cmd_i,
	output osr_resp_s resp_o,
	// Instrument condition bits
	input wire logic [SW-1:0] condition_i,
	// Settings to the analog section
	output logic ac_on_o,
	output logic dc_on_o,
	output logic signed [15:0] dc_bias_o,
	output logic [15:0] ampl_pk_o,
	output logic ampl_unit_o,
	// Status summary
	output logic op_summary_o
);
	logic [1:0] out_code;
	logic dc_saved;
	logic signed [15:0] next_bias;
	logic [15:0] next_ampl;
	logic [15:0] ampl_rms;
	logic wr_unit;
	logic [SW-1:0] cond_q;
	logic [SW-1:0] ev_enable;
	logic [SW-1:0] op_event;
	logic [SW-1:0] fall_f;
	logic [SW-1:0] rise_f;
	logic [SW-1:0] filt_rd;
	logic filt_wr;
	logic rd_pend;
	logic rd_filt;
	logic [15:0] rd_hold;
	logic ev_clr;
	logic [15:0] ampl_in;
	logic [SW-1:0] cond_now;
	logic [SW-1:0] next_event;

	function automatic logic [SW-1:0] stat_mask(input logic [15:0] v);
		stat_mask = SW'(v & OSR_STAT_MASK);
	endfunction

	// Peak value converted to rms, ratio 181/256 approximating 1/sqrt(2).
	// Both conversions round to nearest, so an rms value written reads back unchanged.
	function automatic logic [15:0] pk_to_rms(input logic [15:0] v);
		logic [23:0] p;
		p = 24'(v) * 24'h0000_B5 + 24'h0000_80;
		pk_to_rms = p[23:8];
	endfunction

	function automatic logic [15:0] rms_to_pk(input logic [15:0] v);
		logic [23:0] p;
		p = 24'(v) * 24'h0000_16A + 24'h0000_80;
		rms_to_pk = p[23:8];
	endfunction

	always_comb
	begin
		if ($signed(cmd_i.data) > OSR_DC_MAX)
			next_bias = OSR_DC_MAX;
		else if ($signed(cmd_i.data) < OSR_DC_MIN)
			next_bias = OSR_DC_MIN;
		else
			next_bias = $signed(cmd_i.data);
	end

	always_comb
	begin
		case (cmd_i.sfx)
			OSR_SFX_RMS: wr_unit = OSR_UNIT_RMS;
			OSR_SFX_PK: wr_unit = OSR_UNIT_PK;
			default: wr_unit = ampl_unit_o;
		endcase
	end

	always_comb
	begin
		if (wr_unit == OSR_UNIT_RMS)
		begin
			ampl_in = (cmd_i.data > OSR_RMS_MAX) ? OSR_RMS_MAX : cmd_i.data;
			next_ampl = rms_to_pk(ampl_in);
		end
		else
		begin
			ampl_in = (cmd_i.data > OSR_PK_MAX) ? OSR_PK_MAX : cmd_i.data;
			next_ampl = ampl_in;
		end
	end

	assign ampl_rms = pk_to_rms(ampl_pk_o);

	// Code 0 remembers whether DC was on, so that code 1 can bring it back.
	// output state codes
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			out_code <= OSR_OUT_ALL_OFF;
			ac_on_o <= 1'b0;
			dc_on_o <= 1'b0;
			dc_saved <= 1'b0;
		end
		else if (ce_i && cmd_i.wr && cmd_i.sel == OSR_SEL_OUT_STATE)
		begin
			case (cmd_i.data[1:0])
				OSR_OUT_ALL_OFF:
				begin
					out_code <= OSR_OUT_ALL_OFF;
					ac_on_o <= 1'b0;
					dc_saved <= dc_on_o;
					dc_on_o <= 1'b0;
				end
				OSR_OUT_AC_OFF:
				begin
					out_code <= OSR_OUT_AC_OFF;
					ac_on_o <= 1'b0;
					dc_on_o <= dc_saved;
				end
				OSR_OUT_ALL_ON:
				begin
					out_code <= OSR_OUT_ALL_ON;
					ac_on_o <= 1'b1;
					dc_on_o <= 1'b1;
					dc_saved <= 1'b1;
				end
				default:
				begin
					out_code <= out_code;
				end
			endcase
		end
	end

	// Amplitude is kept in peak form; rms readback is rounded to the nearest hundredth.
	// Writes to the condition and event selectors match nothing here and are dropped.
	// Bias, amplitude and unit settings.
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			dc_bias_o <= '0;
			ampl_pk_o <= '0;
			ampl_unit_o <= OSR_UNIT_RMS;
		end
		else if (ce_i && cmd_i.wr)
		begin
			if (cmd_i.sel == OSR_SEL_DC_BIAS)
				dc_bias_o <= next_bias;
			if (cmd_i.sel == OSR_SEL_AMPL)
				ampl_pk_o <= next_ampl;
			if (cmd_i.sel == OSR_SEL_AMPL_UNIT)
				ampl_unit_o <= cmd_i.data[0];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			ev_enable <= SW'(OSR_STAT_RESET);
		else if (ce_i && cmd_i.wr && cmd_i.sel == OSR_SEL_EV_ENABLE)
			ev_enable <= stat_mask(cmd_i.data);
	end

	assign filt_wr = cmd_i.wr && cmd_i.sel == OSR_SEL_FILTER;

	osr_filter_mem #(
		.WIDTH(SW)
	) u_filt (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.wr_i(filt_wr),
		.wsel_i(cmd_i.sub),
		.wdata_i(stat_mask(cmd_i.data)),
		.rsel_i(cmd_i.sub),
		.rdata_o(filt_rd),
		.fall_o(fall_f),
		.rise_o(rise_f)
	);

	assign cond_now = stat_mask(16'(condition_i));

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			cond_q <= '0;
		else if (ce_i)
			cond_q <= cond_now;
	end

	assign ev_clr = cmd_i.rd && cmd_i.sel == OSR_SEL_EVENT;

	// clear on read
	// A new edge in the clearing cycle survives, so no event is lost.
	always_comb
	begin
		next_event = ev_clr ? '0 : op_event;
		next_event = next_event | (rise_f & cond_now & ~cond_q);
		next_event = next_event | (fall_f & ~cond_now & cond_q);
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			op_event <= '0;
		else if (ce_i)
			op_event <= next_event;
	end

	// The flag trails the event register by one cycle, which keeps it a plain register output.
	// summary flag
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			op_summary_o <= 1'b0;
		else if (ce_i)
			op_summary_o <= |(op_event & ev_enable);
	end

	// Read data capture; filter words come from their memory's read register in the same cycle instead.
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rd_pend <= 1'b0;
			rd_filt <= 1'b0;
			rd_hold <= '0;
		end
		else if (ce_i)
		begin
			rd_pend <= cmd_i.rd;
			rd_filt <= cmd_i.rd && cmd_i.sel == OSR_SEL_FILTER;
			case (cmd_i.sel)
				OSR_SEL_OUT_STATE: rd_hold <= 16'(out_code);
				OSR_SEL_DC_BIAS: rd_hold <= dc_bias_o;
				OSR_SEL_AMPL: rd_hold <= (ampl_unit_o == OSR_UNIT_RMS) ? ampl_rms : ampl_pk_o;
				OSR_SEL_AMPL_UNIT: rd_hold <= 16'(ampl_unit_o);
				OSR_SEL_COND: rd_hold <= 16'(cond_q);
				OSR_SEL_EV_ENABLE: rd_hold <= 16'(ev_enable);
				OSR_SEL_EVENT: rd_hold <= 16'(op_event);
				default: rd_hold <= '0;
			endcase
		end
	end

	// Filter words leave the memory already registered, so they skip the hold stage.
	// filter words top bit zero
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			resp_o <= '0;
		else if (ce_i)
		begin
			resp_o.valid <= rd_pend;
			resp_o.data <= rd_filt ? (16'(filt_rd) & OSR_STAT_MASK) : rd_hold;
		end
	end
endmodule

// ===== core/osr_pkg.sv
// Package for the oscillator settings and operation status register bank.
// Assumes a command parser that decodes text commands into register accesses.
package osr_pkg;
	// Register selectors used on the command port.
	localparam logic [2:0] OSR_SEL_OUT_STATE = 3'h0;
	localparam logic [2:0] OSR_SEL_DC_BIAS = 3'h1;
	localparam logic [2:0] OSR_SEL_AMPL = 3'h2;
	localparam logic [2:0] OSR_SEL_AMPL_UNIT = 3'h3;
	localparam logic [2:0] OSR_SEL_COND = 3'h4;
	localparam logic [2:0] OSR_SEL_EV_ENABLE = 3'h5;
	localparam logic [2:0] OSR_SEL_EVENT = 3'h6;
	localparam logic [2:0] OSR_SEL_FILTER = 3'h7;
	// Output state codes.
	localparam logic [1:0] OSR_OUT_ALL_OFF = 2'h0;
	localparam logic [1:0] OSR_OUT_AC_OFF = 2'h1;
	localparam logic [1:0] OSR_OUT_ALL_ON = 2'h2;
	// Voltages in hundredths of a volt.
	localparam logic signed [15:0] OSR_DC_MAX = 16'sh03E8;
	localparam logic signed [15:0] OSR_DC_MIN = -16'sh03E8;
	localparam logic [15:0] OSR_RMS_MAX = 16'h02C3;
	localparam logic [15:0] OSR_PK_MAX = 16'h03E8;
	localparam logic [15:0] OSR_STAT_MASK = 16'h7FFF;
	localparam logic [15:0] OSR_STAT_RESET = 16'h0000;
	// Amplitude unit encodings.
	localparam logic OSR_UNIT_RMS = 1'b0;
	localparam logic OSR_UNIT_PK = 1'b1;
	// Suffix encodings carried with an amplitude write.
	localparam logic [1:0] OSR_SFX_NONE = 2'h0;
	localparam logic [1:0] OSR_SFX_RMS = 2'h1;
	localparam logic [1:0] OSR_SFX_PK = 2'h2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] sel;
		logic sub;
		logic [1:0] sfx;
		logic [15:0] data;
	} osr_cmd_s;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} osr_resp_s;
endpackage

// ===== core/osr_filter_mem.sv
`timescale 1ns/100ps
// Two-word store for the falling and rising transition filters.
// Assumes the caller masks data before writing; read data are registered.
module osr_filter_mem
	import osr_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	// Clock, reset and enable
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Write port
	input wire logic wr_i,
	input wire logic wsel_i,
	input wire logic [WIDTH-1:0] wdata_i,
	// Registered read port
	input wire logic rsel_i,
	output logic [WIDTH-1:0] rdata_o,
	// Both words in parallel for the edge logic
	output logic [WIDTH-1:0] fall_o,
	output logic [WIDTH-1:0] rise_o
);
	logic [WIDTH-1:0] mem [2];

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			mem[0] <= '0;
			mem[1] <= '0;
		end
		else if (ce_i && wr_i)
		begin
			mem[wsel_i] <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rdata_o <= '0;
		end
		else if (ce_i)
		begin
			rdata_o <= mem[rsel_i];
		end
	end

	assign fall_o = mem[0];
	assign rise_o = mem[1];
endmodule

// ===== tb/osr_regs_checker.sv
// Port checker for the settings and status bank.
// Assumes ce_i stays high while accesses are in flight.
`timescale 1ns/100ps
module osr_regs_checker
	import osr_pkg::*;
#(
	parameter int SW = 16
)
(
	// Watched ports
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire osr_cmd_s cmd_i,
	input wire osr_resp_s resp_o,
	input wire logic [SW-1:0] condition_i,
	input wire logic ac_on_o,
	input wire logic dc_on_o,
	input wire logic signed [15:0] dc_bias_o,
	input wire logic [15:0] ampl_pk_o,
	input wire logic ampl_unit_o,
	input wire logic op_summary_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	logic w;
	assign w = ce_i && cmd_i.wr;
	property p_rd_lat;
		ce_i && cmd_i.rd |-> ##2 resp_o.valid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("late answer");
	property p_no_spur;
		resp_o.valid |-> $past(ce_i && cmd_i.rd, 2);
	endproperty
	a_no_spur: assert property (p_no_spur) else $error("stray answer");
	property p_msb;
		resp_o.valid && $past(cmd_i.sel, 2) >= OSR_SEL_COND |-> !resp_o.data[15];
	endproperty
	a_msb: assert property (p_msb) else $error("status top bit set");
	property p_dc_hi;
		w && cmd_i.sel == OSR_SEL_DC_BIAS && $signed(cmd_i.data) > OSR_DC_MAX
		|=> dc_bias_o == OSR_DC_MAX;
	endproperty
	a_dc_hi: assert property (p_dc_hi) else $error("bias high clamp");
	property p_dc_lo;
		w && cmd_i.sel == OSR_SEL_DC_BIAS && $signed(cmd_i.data) < OSR_DC_MIN
		|=> dc_bias_o == OSR_DC_MIN;
	endproperty
	a_dc_lo: assert property (p_dc_lo) else $error("bias low clamp");
	property p_off;
		w && cmd_i.sel == OSR_SEL_OUT_STATE && cmd_i.data == 16'h0000 |=> !ac_on_o && !dc_on_o;
	endproperty
	a_off: assert property (p_off) else $error("output not off");
	property p_on;
		w && cmd_i.sel == OSR_SEL_OUT_STATE && cmd_i.data == 16'h0002 |=> ac_on_o && dc_on_o;
	endproperty
	a_on: assert property (p_on) else $error("output not on");
	property p_ac_off;
		w && cmd_i.sel == OSR_SEL_OUT_STATE && cmd_i.data == 16'h0001 |=> !ac_on_o;
	endproperty
	a_ac_off: assert property (p_ac_off) else $error("ac still on");
	property p_unit;
		w && cmd_i.sel == OSR_SEL_AMPL_UNIT |=> ampl_unit_o == $past(cmd_i.data[0]);
	endproperty
	a_unit: assert property (p_unit) else $error("unit not taken");
	property p_pk_max;
		w && cmd_i.sel == OSR_SEL_AMPL && cmd_i.sfx == OSR_SFX_PK && cmd_i.data > OSR_PK_MAX
		|=> ampl_pk_o == OSR_PK_MAX;
	endproperty
	a_pk_max: assert property (p_pk_max) else $error("peak clamp");
endmodule

bind osr_regs osr_regs_checker #(.SW(SW)) i_osr_regs_checker (.mclk_i(mclk_i), .rst_i(rst_i),
	.ce_i(ce_i), .cmd_i(cmd_i), .resp_o(resp_o), .condition_i(condition_i), .ac_on_o(ac_on_o),
	.dc_on_o(dc_on_o), .dc_bias_o(dc_bias_o), .ampl_pk_o(ampl_pk_o), .ampl_unit_o(ampl_unit_o),
	.op_summary_o(op_summary_o));

// ===== tb/osr_host.sv
// Host model issuing one decoded access at a time.
// Assumes the bench calls access from one process only.
`timescale 1ns/100ps
module osr_host
	import osr_pkg::*;
(
	// Clock and answer
	input wire logic mclk_i,
	input wire osr_resp_s resp_i,
	// Access
	output osr_cmd_s cmd_o
);
	initial cmd_o = '0;
	task automatic access(input osr_cmd_s c, output logic [15:0] d);
		d = 'x;
		@(negedge mclk_i);
		cmd_o = c;
		@(negedge mclk_i);
		// Stale data are inverted so a late sample cannot pass by luck.
		cmd_o = {2'b00, c.sel, c.sub, c.sfx, ~c.data};
		for (int n = 0; n < 4 && c.rd; n++)
		begin
			@(negedge mclk_i);
			if (resp_i.valid === 1'b1)
			begin
				d = resp_i.data;
				break;
			end
		end
	endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the settings and status bank.
// Assumes the host model drives cmd_i at falling edges.
`timescale 1ns/100ps
module tb_top
	import osr_pkg::*;
;
	typedef struct packed {logic w; logic [2:0] s; logic b; logic [1:0] x;
		logic [15:0] d; logic [15:0] e;} osr_row_s;
	logic mclk_i, rst_i, ce_i, ac_on, dc_on, unit, summ;
	logic [15:0] cond, pk, rd;
	logic signed [15:0] bias;
	osr_cmd_s cmd;
	osr_resp_s resp;
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	osr_row_s rows [0:27] = '{
		'{1,1,0,0,16'h7FFF,0}, '{0,1,0,0,0,16'h03E8}, '{1,1,0,0,16'hF000,0},
		'{0,1,0,0,0,16'hFC18}, '{1,5,0,0,16'hFFFF,0}, '{0,5,0,0,0,16'h7FFF},
		'{1,7,0,0,16'hFFFE,0}, '{0,7,0,0,0,16'h7FFE}, '{1,7,1,0,16'h8001,0},
		'{0,7,1,0,0,16'h0001}, '{1,3,0,0,16'h0001,0}, '{0,3,0,0,0,16'h0001},
		'{1,2,0,0,16'h01F4,0}, '{0,2,0,0,0,16'h01F4}, '{1,2,0,1,16'h0FFF,0},
		'{0,2,0,0,0,16'h03E8}, '{1,3,0,0,16'h0000,0}, '{1,2,0,0,16'h0100,0},
		'{0,2,0,0,0,16'h0100},
		'{1,2,0,2,16'h07D0,0}, '{0,2,0,0,0,16'h02C3}, '{1,4,0,0,16'h1234,0},
		'{0,4,0,0,0,16'h0000}, '{1,0,0,0,16'h0002,0}, '{1,0,0,0,16'h0003,0},
		'{0,0,0,0,0,16'h0002}, '{1,6,0,0,16'hFFFF,0}, '{0,6,0,0,0,16'h0000}};
	osr_regs #(.SW(16)) i_osr_regs (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_i(cmd),
		.resp_o(resp), .condition_i(cond), .ac_on_o(ac_on), .dc_on_o(dc_on), .dc_bias_o(bias),
		.ampl_pk_o(pk), .ampl_unit_o(unit), .op_summary_o(summ));
	osr_host i_osr_host (.mclk_i(mclk_i), .resp_i(resp), .cmd_o(cmd));
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic op(input osr_row_s r);
		i_osr_host.access({r.w, ~r.w, r.s, r.b, r.x, r.d}, rd);
		if (!r.w)
			check(rd, r.e);
	endtask
	initial
	begin
		mclk_i = 0;
		forever #5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			close_out();
		end
	end
	initial
	begin
		rst_i = 1;
		ce_i = 1;
		cond = 16'h0000;
		repeat (16) @(negedge mclk_i);
		rst_i = 0;
		check({12'h000, ac_on, dc_on, unit, summ}, 16'h0000);
		check(bias | pk, 16'h0000);
		foreach (rows[i])
			op(rows[i]);
		check(bias, 16'hFC18);
		check(pk, OSR_PK_MAX);
		op('{1,0,0,0,16'h0000,0});
		check({14'h0000, ac_on, dc_on}, 16'h0000);
		op('{1,0,0,0,16'h0001,0});
		check({14'h0000, ac_on, dc_on}, 16'h0001);
		op('{0,0,0,0,0,16'h0001});
		cond = 16'h0003;
		repeat (3) @(negedge mclk_i);
		check({15'h0000, summ}, 16'h0001);
		op('{0,6,0,0,0,16'h0001});
		cond = 16'h0000;
		repeat (3) @(negedge mclk_i);
		op('{0,6,0,0,0,16'h0002});
		op('{0,6,0,0,0,16'h0000});
		repeat (2) @(negedge mclk_i);
		check({15'h0000, summ}, 16'h0000);
		cond = 16'h8005;
		repeat (3) @(negedge mclk_i);
		op('{0,4,0,0,0,16'h0005});
		// Let the answer pulse end before freezing, or it would stand on.
		@(negedge mclk_i);
		ce_i = 0;
		op('{1,1,0,0,16'h0000,0});
		check(bias, 16'hFC18);
		ce_i = 1;
		rst_i = 1;
		repeat (2) @(negedge mclk_i);
		rst_i = 0;
		check({12'h000, ac_on, dc_on, unit, summ}, 16'h0000);
		check(bias | pk, 16'h0000);
		op('{0,5,0,0,0,16'h0000});
		close_out();
	end
endmodule
